//--- logic/iadt_pkg.sv
// constants and types shared by the address/data transfer block
package iadt_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_LOW_NS    = 4700;
    localparam int SCL_HIGH_NS   = 4000;
    localparam int CNT_W         = 9;
    // least times, rounded up to whole cycles
    localparam logic [CNT_W-1:0] SCL_LOW_CYC  =
        CNT_W'((SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SCL_HIGH_CYC =
        CNT_W'((SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ZERO     = 9'h000;
    localparam logic [CNT_W-1:0] CNT_STEP     = 9'h001;

    // ****************************************
    // byte framing
    // ****************************************
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    localparam logic [3:0] BIT_FIRST     = 4'h0;
    localparam logic [3:0] BIT_STEP      = 4'h1;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_BITS = 2'b01,
        S_WAIT = 2'b10
    } iadt_slv_st_type;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_WAIT = 3'b001,
        M_LOW  = 3'b010,
        M_REL  = 3'b011,
        M_HIGH = 3'b100
    } iadt_mst_st_type;

    typedef struct packed {
        logic addr_match;
        logic end_addr;
        logic end_xfer;
    } iadt_evt_type;

    localparam iadt_evt_type EVT_NONE = 3'h0;
endpackage

//--- logic/iadt_sync.sv
// two-stage synchroniser for the clock and data lines
`timescale 1ns/1ps
module iadt_sync (
    input  wire logic       clk_sys_i,
    input  wire logic       srst_i,
    input  wire logic [1:0] async_i,
    output logic      [1:0] sync_o
);
    // ****************************************
    // two flops, first read only by second
    // ****************************************
    logic [1:0] meta_ff;
    logic [1:0] sync_ff;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            meta_ff <= 2'h3;
            sync_ff <= 2'h3;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule

//--- logic/iadt_core.sv
// two-wire peer: address and data phases of a master-transmit transfer
// Function
// - matched slave acks address; master samples ack at ninth rising edge
// - master interrupts end of address at ninth falling edge
// - matched slave holds clock low after address and interrupts
// - master byte write loads data and releases master wait
// - master waits for released clock line before clocking next byte
// - slave acks data when ack enable set; master samples at ninth rise
// - at ninth fall of data both hold clock low and interrupt
// - unmatched slave gives no ack, no interrupt, no wait
// - master interrupts end of address whether acked or not
`timescale 1ns/1ps
module iadt_core
    import iadt_pkg::*;
(
    input  wire logic         clk_sys_i,
    input  wire logic         srst_i,
    input  wire logic         master_mode_i,
    input  wire logic         arm_i,
    input  wire logic [6:0]   own_address_value_i,
    input  wire logic         ack_enable_bit_i,
    input  wire logic         wait_release_bit_i,
    input  wire logic         tx_wr_i,
    input  wire logic [7:0]   tx_data_i,
    input  wire logic         clock_line_i,
    output logic              clock_line_o,
    output logic              clock_line_oe_o,
    input  wire logic         data_line_i,
    output logic              data_line_o,
    output logic              data_line_oe_o,
    output logic              bus_event_interrupt_o,
    output iadt_evt_type      event_o,
    output logic              ack_detected_flag_o,
    output logic [7:0]        rx_data_o
);
    // ****************************************
    // line sampling
    // ****************************************
    logic [1:0] line_s;
    logic       scl_s;
    logic       sda_s;
    logic       scl_q_ff;
    logic       scl_rise;
    logic       scl_fall;

    iadt_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .async_i   ({clock_line_i, data_line_i}),
        .sync_o    (line_s)
    );

    assign scl_s = line_s[1];
    assign sda_s = line_s[0];

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            scl_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_s;
        end
    end

    assign scl_rise = scl_s & ~scl_q_ff;
    assign scl_fall = ~scl_s & scl_q_ff;

    // ****************************************
    // slave side
    // ****************************************
    iadt_slv_st_type slv_st_ff;
    logic [3:0]      slv_cnt_ff;
    logic [7:0]      slv_sh_ff;
    logic            slv_addr_ff;
    logic            slv_rose_ff;
    logic            slv_sda_ff;
    logic            wait_release_bit_ff;
    logic            nxt_wait_release_bit;
    iadt_evt_type    slv_evt_ff;
    logic [7:0]      rx_data_ff;
    logic            slv_ack_due;

    // address compare uses the upper seven bits of the first byte, r/w bit ignored
    assign slv_ack_due = slv_addr_ff ? (slv_sh_ff[7:1] == own_address_value_i)
                                     : ack_enable_bit_i;

    // set wins over the self-clear
    assign nxt_wait_release_bit = wait_release_bit_i | (wait_release_bit_ff & (slv_st_ff != S_WAIT));

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wait_release_bit_ff <= 1'b0;
        end else begin
            wait_release_bit_ff <= nxt_wait_release_bit;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            slv_st_ff   <= S_IDLE;
            slv_cnt_ff  <= BIT_FIRST;
            slv_sh_ff   <= 8'h00;
            slv_addr_ff <= 1'b0;
            slv_rose_ff <= 1'b0;
            slv_sda_ff  <= 1'b0;
            slv_evt_ff  <= EVT_NONE;
            rx_data_ff  <= 8'h00;
        end else begin
            slv_evt_ff <= EVT_NONE;
            unique case (slv_st_ff)
                S_IDLE: begin
                    if (arm_i && !master_mode_i) begin
                        slv_st_ff   <= S_BITS;
                        slv_cnt_ff  <= BIT_FIRST;
                        slv_addr_ff <= 1'b1;
                        slv_rose_ff <= 1'b0;
                    end
                end
                S_BITS: begin
                    if (scl_rise && slv_cnt_ff != BIT_ACK) begin
                        slv_sh_ff <= {slv_sh_ff[6:0], sda_s};
                    end
                    if (scl_rise) begin
                        slv_rose_ff <= 1'b1;
                    end
                    // the fall that opens the first byte carries no bit
                    if (scl_fall && slv_rose_ff) begin
                        if (slv_cnt_ff == BIT_LAST_DATA) begin
                            if (slv_addr_ff && !slv_ack_due) begin
                                slv_st_ff <= S_IDLE;
                            end else begin
                                slv_sda_ff <= slv_ack_due;
                                slv_cnt_ff <= BIT_ACK;
                            end
                        end else if (slv_cnt_ff == BIT_ACK) begin
                            slv_sda_ff <= 1'b0;
                            slv_st_ff  <= S_WAIT;
                            if (slv_addr_ff) begin
                                slv_evt_ff.addr_match <= 1'b1;
                            end else begin
                                slv_evt_ff.end_xfer <= 1'b1;
                                rx_data_ff          <= slv_sh_ff;
                            end
                        end else begin
                            slv_cnt_ff <= slv_cnt_ff + BIT_STEP;
                        end
                    end
                end
                S_WAIT: begin
                    // stays low until control has read the byte and released
                    if (wait_release_bit_ff) begin
                        slv_st_ff   <= S_BITS;
                        slv_cnt_ff  <= BIT_FIRST;
                        slv_addr_ff <= 1'b0;
                        slv_rose_ff <= 1'b0;
                    end
                end
                default: begin
                    slv_st_ff <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // master side
    // ****************************************
    iadt_mst_st_type  mst_st_ff;
    logic [3:0]       mst_bit_ff;
    logic [7:0]       mst_sh_ff;
    logic [CNT_W-1:0] mst_cnt_ff;
    logic             mst_addr_ff;
    logic             mst_sda_ff;
    logic             ack_ff;
    iadt_evt_type     mst_evt_ff;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mst_st_ff   <= M_IDLE;
            mst_bit_ff  <= BIT_FIRST;
            mst_sh_ff   <= 8'h00;
            mst_cnt_ff  <= CNT_ZERO;
            mst_addr_ff <= 1'b0;
            mst_sda_ff  <= 1'b0;
            ack_ff      <= 1'b0;
            mst_evt_ff  <= EVT_NONE;
        end else begin
            mst_evt_ff <= EVT_NONE;
            unique case (mst_st_ff)
                M_IDLE: begin
                    if (arm_i && master_mode_i) begin
                        mst_st_ff   <= M_WAIT;
                        mst_addr_ff <= 1'b1;
                    end
                end
                M_WAIT: begin
                    if (tx_wr_i) begin
                        mst_sh_ff  <= tx_data_i;
                        mst_sda_ff <= ~tx_data_i[7];
                        mst_bit_ff <= BIT_FIRST;
                        mst_cnt_ff <= SCL_LOW_CYC;
                        mst_st_ff  <= M_LOW;
                    end
                end
                M_LOW: begin
                    if (mst_cnt_ff == CNT_ZERO) begin
                        mst_st_ff <= M_REL;
                    end else begin
                        mst_cnt_ff <= mst_cnt_ff - CNT_STEP;
                    end
                end
                M_REL: begin
                    // a stretching slave keeps us here until it lets go
                    if (scl_s) begin
                        mst_st_ff  <= M_HIGH;
                        mst_cnt_ff <= SCL_HIGH_CYC;
                        if (mst_bit_ff == BIT_ACK) begin
                            ack_ff <= ~sda_s;
                        end
                    end
                end
                M_HIGH: begin
                    if (mst_cnt_ff != CNT_ZERO) begin
                        mst_cnt_ff <= mst_cnt_ff - CNT_STEP;
                    end else if (mst_bit_ff == BIT_ACK) begin
                        mst_st_ff   <= M_WAIT;
                        mst_sda_ff  <= 1'b0;
                        mst_addr_ff <= 1'b0;
                        // raised on ack and nack alike
                        mst_evt_ff.end_addr <= mst_addr_ff;
                        mst_evt_ff.end_xfer <= ~mst_addr_ff;
                    end else begin
                        mst_bit_ff <= mst_bit_ff + BIT_STEP;
                        mst_sh_ff  <= {mst_sh_ff[6:0], 1'b1};
                        mst_sda_ff <= (mst_bit_ff != BIT_LAST_DATA) & ~mst_sh_ff[6];
                        mst_cnt_ff <= SCL_LOW_CYC;
                        mst_st_ff  <= M_LOW;
                    end
                end
                default: begin
                    mst_st_ff <= M_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // pins and events
    // ****************************************
    assign clock_line_o          = 1'b0;
    assign data_line_o           = 1'b0;
    assign clock_line_oe_o       = (slv_st_ff == S_WAIT) || (mst_st_ff == M_WAIT)
                                   || (mst_st_ff == M_LOW);
    assign data_line_oe_o        = slv_sda_ff | mst_sda_ff;
    assign event_o               = slv_evt_ff | mst_evt_ff;
    assign bus_event_interrupt_o = |event_o;
    assign ack_detected_flag_o   = ack_ff;
    assign rx_data_o             = rx_data_ff;

    // ****************************************
    // checks
    // ****************************************
    mst_irq_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (mst_st_ff == M_HIGH && mst_cnt_ff == CNT_ZERO && mst_bit_ff == BIT_ACK
         && mst_addr_ff) |=> (event_o.end_addr && clock_line_oe_o))
        else $error("no end of address event at ninth fall");
    nack_irq_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (mst_st_ff == M_REL && scl_s && mst_bit_ff == BIT_ACK && mst_addr_ff && sda_s)
        |=> ##[1:500] event_o.end_addr)
        else $error("nack address gave no event");
    ack_sample_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (mst_st_ff == M_REL && scl_s && mst_bit_ff == BIT_ACK)
        |=> (ack_detected_flag_o == !$past(sda_s)))
        else $error("ack flag not sampled at ninth rise");
    slv_wait_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        $rose(event_o.addr_match) |-> (clock_line_oe_o && slv_st_ff == S_WAIT))
        else $error("address match without wait");
    nomatch_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (slv_st_ff == S_BITS && scl_fall && slv_cnt_ff == BIT_LAST_DATA && slv_addr_ff
         && slv_sh_ff[7:1] != own_address_value_i)
        |=> (slv_st_ff == S_IDLE && !slv_sda_ff) [*2])
        else $error("unmatched slave acted");
    tx_load_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (mst_st_ff == M_WAIT && tx_wr_i)
        |=> (mst_st_ff == M_LOW && mst_sh_ff == $past(tx_data_i)))
        else $error("byte write did not load and release");
    stretch_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (mst_st_ff == M_REL && !scl_s) |=> (mst_st_ff == M_REL))
        else $error("master clocked over a held clock line");
    data_ack_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (slv_st_ff == S_BITS && scl_fall && slv_cnt_ff == BIT_LAST_DATA && !slv_addr_ff)
        |=> (data_line_oe_o == $past(ack_enable_bit_i)))
        else $error("data ack does not follow ack enable");
    end_xfer_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (slv_st_ff == S_BITS && scl_fall && slv_cnt_ff == BIT_ACK && !slv_addr_ff)
        |=> (event_o.end_xfer && clock_line_oe_o && rx_data_o == $past(slv_sh_ff)))
        else $error("slave end of transfer missing");
    wait_release_bit_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (slv_st_ff == S_WAIT && wait_release_bit_ff && !wait_release_bit_i)
        |=> (!wait_release_bit_ff && slv_st_ff == S_BITS))
        else $error("wait release bit did not self clear");
endmodule

//--- dv/iadt_peer_model.sv
// behavioural far-side peer: paced master or acking, stretching slave
`timescale 1ns/1ps
module iadt_peer_model (
    input  wire logic        rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    input  wire logic        slv_on_i,
    input  wire logic        ack_en_i,
    input  wire logic [15:0] stretch_ns_i,
    output logic             scl_oe_o,
    output logic             sda_oe_o,
    output logic [7:0]       byte_o
);
    logic [7:0] sh;
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        byte_o = 8'h00;
        sh = 8'h00;
    end
    // master role, 80 ns link clock; line stays low between bytes
    task automatic mst_byte(input logic [7:0] b, output logic ack);
        int k;
        ack = 1'b0;
        for (int i = 8; i >= 0; i--) begin
            scl_oe_o = 1'b1;
            #20 sda_oe_o = (i > 0) ? ~b[i-1] : 1'b0;
            #20 scl_oe_o = 1'b0;
            for (k = 0; k < 20000 && scl_i !== 1'b1; k++) #10;
            #40 ack = (i == 0) ? ~sda_i : ack;
            scl_oe_o = 1'b1;
        end
    endtask
    // slave role: pull-up makes a released data line read high
    always begin : slv_loop
        wait (slv_on_i === 1'b1 && rst_i === 1'b0);
        for (int i = 0; i < 8; i++) begin
            @(posedge scl_i);
            sh = {sh[6:0], sda_i};
        end
        @(negedge scl_i);
        #15 sda_oe_o = ack_en_i;
        @(negedge scl_i);
        scl_oe_o = (stretch_ns_i != 16'h0000);
        #15 sda_oe_o = 1'b0;
        byte_o = sh;
        #(stretch_ns_i) scl_oe_o = 1'b0;
    end
    always @(posedge rst_i) begin
        disable slv_loop;
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
endmodule

//--- dv/iadt_core_tb_top.sv
// self-checking bench for the address/data transfer block
`timescale 1ns/1ps
module iadt_core_tb_top;
    import iadt_pkg::*;
    logic         clk_sys_i, srst_i, master_mode_i, arm_i, tx_wr_i;
    logic         ack_enable_bit_i, wait_release_bit_i, slv_on, p_ack_en, ack;
    logic [6:0]   own_address_value_i;
    logic [7:0]   tx_data_i, rx_data, p_byte;
    logic         scl_oe, sda_oe, irq, ack_detected_flag, p_scl_oe, p_sda_oe, scl_o, sda_o;
    logic [15:0]  stretch_ns;
    iadt_evt_type evt;
    int           n_tests, n_mismatch, n_am, n_ex, n_irq;
    wire          scl_w = ~(scl_oe | p_scl_oe);
    wire          sda_w = ~(sda_oe | p_sda_oe);

    iadt_core dut_u (.clk_sys_i, .srst_i, .master_mode_i, .arm_i, .own_address_value_i,
        .ack_enable_bit_i, .wait_release_bit_i, .tx_wr_i, .tx_data_i,
        .clock_line_i(scl_w), .clock_line_o(scl_o), .clock_line_oe_o(scl_oe),
        .data_line_i(sda_w), .data_line_o(sda_o), .data_line_oe_o(sda_oe),
        .bus_event_interrupt_o(irq), .event_o(evt), .ack_detected_flag_o(ack_detected_flag),
        .rx_data_o(rx_data));
    iadt_peer_model p_u (.rst_i(srst_i), .scl_i(scl_w), .sda_i(sda_w), .slv_on_i(slv_on),
        .ack_en_i(p_ack_en), .stretch_ns_i(stretch_ns), .scl_oe_o(p_scl_oe),
        .sda_oe_o(p_sda_oe), .byte_o(p_byte));

    // ****************************************
    // helpers
    // ****************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        n_am <= srst_i ? 0 : n_am + int'(evt.addr_match === 1'b1);
        n_ex <= srst_i ? 0 : n_ex + int'(evt.end_xfer === 1'b1);
        n_irq <= srst_i ? 0 : n_irq + int'(irq === 1'b1);
    end
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkb(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic do_reset(input logic mode);
        @(negedge clk_sys_i);
        srst_i = 1'b1;
        master_mode_i = mode;
        repeat (4) @(negedge clk_sys_i);
        srst_i = 1'b0;
    endtask
    task automatic pulse(ref logic sig);
        @(negedge clk_sys_i);
        sig = 1'b1;
        @(negedge clk_sys_i);
        sig = 1'b0;
    endtask
    // polls the pulse itself so the event fields are read while they stand
    task automatic wait_irq();
        int k;
        for (k = 0; k < 12000 && irq !== 1'b1; k++) @(negedge clk_sys_i);
        chkb("event seen", 1'b1, k < 12000);
    endtask
    task automatic slv_data(input logic [7:0] b, input logic ack_en);
        logic a;
        ack_enable_bit_i = ack_en;
        fork
            p_u.mst_byte(b, a);
            begin
                repeat (30) @(negedge clk_sys_i);
                chkb("held", 1'b1, scl_oe);
                pulse(wait_release_bit_i);
                repeat (2) @(negedge clk_sys_i);
                chkb("released", 1'b0, scl_oe);
            end
        join
        chkb("data ack", ack_en, a);
        repeat (10) @(negedge clk_sys_i);
        chk8("rx data", b, rx_data);
        chkb("data wait", 1'b1, scl_oe);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_slave_match();
        do_reset(1'b0);
        own_address_value_i = 7'h2a;
        pulse(arm_i);
        p_u.mst_byte(8'h54, ack);
        chkb("addr ack", 1'b1, ack);
        repeat (10) @(negedge clk_sys_i);
        chk8("match events", 8'h01, 8'(n_am));
        repeat (40) @(negedge clk_sys_i);
        chkb("addr wait", 1'b1, scl_oe);
        slv_data(8'ha5, 1'b1);
        slv_data(8'h3c, 1'b0);
        chk8("xfer events", 8'h02, 8'(n_ex));
        chk8("irq count", 8'h03, 8'(n_irq));
        $display("done: slave match");
    endtask
    task automatic t_slave_miss();
        do_reset(1'b0);
        pulse(arm_i);
        p_u.mst_byte(8'h2a, ack);
        chkb("miss nack", 1'b0, ack);
        repeat (10) @(negedge clk_sys_i);
        chk8("miss irq", 8'h00, 8'(n_irq));
        chkb("miss wait", 1'b0, scl_oe);
        $display("done: slave mismatch");
    endtask
    task automatic t_master(input logic ack_en, input logic [15:0] st);
        do_reset(1'b1);
        p_ack_en = ack_en;
        stretch_ns = st;
        slv_on = 1'b1;
        pulse(arm_i);
        tx_data_i = 8'h54;
        pulse(tx_wr_i);
        wait_irq();
        chkb("end addr", 1'b1, evt.end_addr);
        chkb("addr ack_detected_flag", ack_en, ack_detected_flag);
        chkb("mst wait", 1'b1, scl_oe);
        chkb("pin drive level", 1'b0, scl_o | sda_o);
        repeat (3) @(negedge clk_sys_i);
        chk8("addr wire", 8'h54, p_byte);
        tx_data_i = 8'hc3;
        pulse(tx_wr_i);
        wait_irq();
        chkb("end xfer", 1'b1, evt.end_xfer);
        chkb("data ack_detected_flag", ack_en, ack_detected_flag);
        chkb("mst data wait", 1'b1, scl_oe);
        repeat (3) @(negedge clk_sys_i);
        chk8("data wire", 8'hc3, p_byte);
        slv_on = 1'b0;
        $display("done: master ack %b", ack_en);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        {srst_i, master_mode_i, arm_i, tx_wr_i, ack_enable_bit_i} = 5'h10;
        {wait_release_bit_i, slv_on, p_ack_en} = 3'h0;
        own_address_value_i = 7'h2a;
        tx_data_i = 8'h00;
        stretch_ns = 16'h0000;
        n_tests = 0;
        n_mismatch = 0;
        repeat (4) @(negedge clk_sys_i);
        srst_i = 1'b0;
        t_slave_match();
        t_slave_miss();
        t_master(1'b1, 16'h2328);
        t_master(1'b0, 16'h0000);
        final_report();
    end
    // run needs about 32000 cycles
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        n_mismatch++;
        $display("[FAIL] watchdog expected done seen hang");
        final_report();
    end
endmodule
